// ===== design/dclf_pkg.sv
// shared constants and carrier types for the dual clock line delay fifo
package dclf_pkg;

    localparam int          DCLF_DEPTH      = 5048;
    localparam int          DCLF_WIDTH      = 8;
    localparam int          DCLF_ADDR_W     = 13;
    localparam int          DCLF_BUF_DEPTH  = 2;
    localparam logic [12:0] DCLF_LAST_ADDR  = 13'h13b7;
    localparam logic [12:0] DCLF_PTR_RESET  = 13'h0000;
    localparam logic [7:0]  DCLF_WORD_RESET = 8'h00;
    localparam int          DCLF_SYNC_DEPTH = 3;

    // least write-to-read spacing the consumer keeps, in ns and core cycles
    localparam int          DCLF_CORE_PERIOD_NS = 20;
    localparam int          DCLF_WAR_NS         = 470;
    localparam int          DCLF_WAR_CYCLES     =
        (DCLF_WAR_NS + DCLF_CORE_PERIOD_NS - 1) / DCLF_CORE_PERIOD_NS;

    // a write taken at the opening edge, stored at the closing edge
    typedef struct packed {
        logic                   pending;
        logic [12:0]            addr;
    } dclf_wr_s;

    // a word on its way out of the read side
    typedef struct packed {
        logic                   valid;
        logic [7:0]             word;
    } dclf_rd_s;

endpackage

// ===== design/dclf_out_buffer.sv
// two-entry valid/ready buffer on the read data path
`timescale 1ns/10ps
`default_nettype none

module dclf_out_buffer
    import dclf_pkg::*;
#(
    parameter int WIDTH = DCLF_WIDTH,
    parameter int DEPTH = DCLF_BUF_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             en,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    initial begin
        if (DEPTH != 2 || WIDTH < 1) begin
            $error("dclf_out_buffer: DEPTH must be 2 and WIDTH at least 1");
        end
    end

    logic [WIDTH-1:0] slot_ff [DEPTH];
    logic             wr_idx_ff;
    logic             rd_idx_ff;
    logic [1:0]       count_ff;
    logic             push;
    logic             pop;

    assign in_ready  = (count_ff != 2'h2);
    assign out_valid = (count_ff != 2'h0);
    assign out_data  = slot_ff[rd_idx_ff];
    assign push      = en && in_valid && in_ready;
    assign pop       = en && out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_idx_ff <= 1'b0;
            rd_idx_ff <= 1'b0;
            count_ff  <= 2'h0;
        end else begin
            if (push) begin
                wr_idx_ff <= ~wr_idx_ff;
            end
            if (pop) begin
                rd_idx_ff <= ~rd_idx_ff;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 2'h1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 2'h1;
            end
        end
    end

    // storage carries no reset; validity lives in count_ff
    always_ff @(posedge clk) begin
        if (push) begin
            slot_ff[wr_idx_ff] <= in_data;
        end
    end

endmodule

`default_nettype wire

// ===== design/dclf_line_fifo.sv
// dual clock 5048 by 8 line delay fifo, write side on core clock
`timescale 1ns/10ps
`default_nettype none

module dclf_line_fifo
    import dclf_pkg::*;
#(
    parameter int DEPTH = DCLF_DEPTH,
    parameter int WIDTH = DCLF_WIDTH
) (
    input  wire logic             CORE_CLK,
    input  wire logic             RESET,
    input  wire logic             CLK_EN,
    input  wire logic             WRITE_ENABLE_N,
    input  wire logic             WRITE_POINTER_RESET_N,
    input  wire logic [WIDTH-1:0] WRITE_WORD_IN,
    input  wire logic             READ_SIDE_CLOCK,
    input  wire logic             READ_ENABLE_N,
    input  wire logic             READ_POINTER_RESET_N,
    input  wire logic             READ_READY,
    output logic                  READ_VALID,
    output logic      [WIDTH-1:0] READ_WORD_OUT,
    output logic                  READ_WORD_OE
);

    initial begin
        if (DEPTH < 2 || DEPTH > (1 << DCLF_ADDR_W) || WIDTH < 1) begin
            $error("dclf_line_fifo: DEPTH or WIDTH out of range");
        end
    end

    localparam logic [12:0] LAST = 13'(DEPTH - 1);

    ////////////////////////////////////////////////////////////////////////
    // storage: written only on the core clock, read on the link clock

    logic [WIDTH-1:0] line_mem_ff [DEPTH];

    ////////////////////////////////////////////////////////////////////////
    // write side, core clock domain

    logic [12:0] wr_ptr_ff;
    dclf_wr_s    wr_req_ff;

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            wr_ptr_ff <= DCLF_PTR_RESET;
        end else if (CLK_EN) begin
            if (!WRITE_POINTER_RESET_N) begin
                wr_ptr_ff <= DCLF_PTR_RESET;
            end else if (!WRITE_ENABLE_N) begin
                wr_ptr_ff <= (wr_ptr_ff == LAST) ? DCLF_PTR_RESET : wr_ptr_ff + 13'h0001;
            end
        end
    end

    // opening edge marks the cycle for storing
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            wr_req_ff <= '{pending: 1'b0, addr: DCLF_PTR_RESET};
        end else if (CLK_EN) begin
            wr_req_ff.pending <= !WRITE_ENABLE_N && WRITE_POINTER_RESET_N;
            wr_req_ff.addr    <= wr_ptr_ff;
        end
    end

    // data taken at the closing edge of the cycle
    always_ff @(posedge CORE_CLK) begin
        if (CLK_EN && !RESET && wr_req_ff.pending) begin
            line_mem_ff[wr_req_ff.addr] <= WRITE_WORD_IN;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // level crossings of core reset and clock enable into the link domain

    logic [DCLF_SYNC_DEPTH-1:0] rst_sync_ff;
    logic [DCLF_SYNC_DEPTH-1:0] cen_sync_ff;
    logic                       rd_rst_ff;
    logic                       rd_cen_ff;

    // three stages, change taken once the last two agree
    always_ff @(posedge READ_SIDE_CLOCK) begin
        rst_sync_ff <= {rst_sync_ff[1:0], RESET};
        cen_sync_ff <= {cen_sync_ff[1:0], CLK_EN};
    end

    always_ff @(posedge READ_SIDE_CLOCK) begin
        if (rst_sync_ff[1] == rst_sync_ff[2]) begin
            rd_rst_ff <= rst_sync_ff[2];
        end
        if (cen_sync_ff[1] == cen_sync_ff[2]) begin
            rd_cen_ff <= cen_sync_ff[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read side, link clock domain

    logic [12:0]      rd_ptr_ff;
    logic             rd_take;
    logic             buf_ready;
    logic             buf_valid;
    logic [WIDTH-1:0] buf_word;
    logic             oe_ff;

    // a full buffer stalls the read rather than dropping a word
    assign rd_take = rd_cen_ff && !READ_ENABLE_N && READ_POINTER_RESET_N && buf_ready;

    always_ff @(posedge READ_SIDE_CLOCK) begin
        if (rd_rst_ff) begin
            rd_ptr_ff <= DCLF_PTR_RESET;
        end else if (rd_cen_ff) begin
            if (!READ_POINTER_RESET_N) begin
                rd_ptr_ff <= DCLF_PTR_RESET;
            end else if (rd_take) begin
                rd_ptr_ff <= (rd_ptr_ff == LAST) ? DCLF_PTR_RESET : rd_ptr_ff + 13'h0001;
            end
        end
    end

    // word settled long before the consumer reaches it
    dclf_out_buffer #(
        .WIDTH     (WIDTH),
        .DEPTH     (DCLF_BUF_DEPTH)
    ) u_out_buffer (
        .clk       (READ_SIDE_CLOCK),
        .rst       (rd_rst_ff),
        .en        (rd_cen_ff),
        .in_valid  (rd_take),
        .in_ready  (buf_ready),
        .in_data   (line_mem_ff[rd_ptr_ff]),
        .out_valid (buf_valid),
        // a word hidden by a released output is never popped
        .out_ready (READ_READY && oe_ff),
        .out_data  (buf_word)
    );

    // drivers released while read enable sampled high
    always_ff @(posedge READ_SIDE_CLOCK) begin
        if (rd_rst_ff) begin
            oe_ff <= 1'b0;
        end else if (rd_cen_ff) begin
            oe_ff <= !READ_ENABLE_N;
        end
    end

    // word shows on the pins while enabled and held
    assign READ_VALID    = buf_valid && oe_ff;
    assign READ_WORD_OE  = oe_ff && buf_valid;
    assign READ_WORD_OUT = READ_WORD_OE ? buf_word : DCLF_WORD_RESET;

endmodule

`default_nettype wire

// ===== tb/dclf_line_fifo_props.sv
// read side checker of the line fifo
`timescale 1ns/10ps
`default_nettype none
module dclf_line_fifo_props
    import dclf_pkg::*;
#(parameter int WIDTH = DCLF_WIDTH) (
    input wire logic             READ_SIDE_CLOCK,
    input wire logic             RESET,
    input wire logic             READ_ENABLE_N,
    input wire logic             READ_POINTER_RESET_N,
    input wire logic             READ_READY,
    input wire logic             READ_VALID,
    input wire logic [WIDTH-1:0] READ_WORD_OUT,
    input wire logic             READ_WORD_OE
);
    default clocking @(posedge READ_SIDE_CLOCK); endclocking
    default disable iff (RESET);
    ////////////////////
    AST_OE_VALID: assert property (READ_WORD_OE == READ_VALID)
        else $error("oe and valid differ");
    AST_ZERO_OFF: assert property (!READ_WORD_OE |-> READ_WORD_OUT == '0)
        else $error("word not released");
    AST_ENA_OFF: assert property (READ_ENABLE_N |=> !READ_WORD_OE)
        else $error("output kept with enable high");
    AST_HOLD: assert property (READ_VALID && !READ_READY && !READ_ENABLE_N
        |=> READ_VALID && $stable(READ_WORD_OUT)) else $error("stalled word lost");
    AST_NEXT: assert property (!READ_ENABLE_N && READ_VALID && READ_READY
        && READ_POINTER_RESET_N |=> READ_VALID) else $error("no next word");
    AST_FALL: assert property ($fell(READ_WORD_OE) && $past(READ_POINTER_RESET_N)
        |-> $past(READ_ENABLE_N)) else $error("output dropped while reading");
    AST_RISE: assert property ($rose(READ_VALID) |-> !$past(READ_ENABLE_N))
        else $error("word without read");
    // reset crossing takes a few read edges, so judging starts at the sixth
    AST_IDLE: assert property (disable iff (1'b0) RESET [*6]
        |-> !READ_VALID && READ_WORD_OUT == '0) else $error("busy in reset");
endmodule
bind dclf_line_fifo dclf_line_fifo_props #(.WIDTH(WIDTH)) i_dclf_line_fifo_props (
    .READ_SIDE_CLOCK, .RESET, .READ_ENABLE_N, .READ_POINTER_RESET_N, .READ_READY,
    .READ_VALID, .READ_WORD_OUT, .READ_WORD_OE);
`default_nettype wire

// ===== tb/dclf_consumer.sv
// scan data consumer on the read side
`timescale 1ns/10ps
`default_nettype none
module dclf_consumer (
    input  wire logic       rclk,
    input  wire logic       run,
    input  wire logic       prst,
    input  wire logic       valid,
    input  wire logic [7:0] word,
    output logic            enable_n,
    output logic            ready,
    output logic            ptr_reset_n,
    output logic [12:0]     count
);
    logic [7:0] seen [0:8191];
    logic [3:0] phase;
    initial begin
        enable_n = 1;
        ready = 0;
        ptr_reset_n = 1;
        count = '0;
        phase = '0;
    end
    // reads start after the line is written
    always @(posedge rclk) begin
        phase <= phase + 4'h1;
        ptr_reset_n <= !prst;
        enable_n <= !run || phase == 4'hc;
        // six idle edges, longer than the buffer can absorb
        ready <= run && phase < 4'ha;
        if (prst)
            count <= '0;
        else if (valid && ready) begin
            seen[count] <= word;
            count <= count + 13'h1;
        end
    end
endmodule
`default_nettype wire

// ===== tb/tb_dclf_line_fifo.sv
// bench of the line fifo with a consumer model
`timescale 1ns/10ps
`default_nettype none
module tb_dclf_line_fifo;
    import dclf_pkg::*;
    logic        clk, rclk, rst, we_n, wrst_n, run, prst;
    logic        rv, oe, ren_n, rrdy, rrst_n;
    logic [7:0]  wd, rd;
    logic [12:0] cnt;
    int          err_count, check_count;
    initial begin clk = 0; forever #10 clk = ~clk; end
    initial begin rclk = 0; #3.7; forever #62.5 rclk = ~rclk; end
    dclf_line_fifo i_dclf_line_fifo (.CORE_CLK(clk), .RESET(rst), .CLK_EN(1'b1),
        .WRITE_ENABLE_N(we_n), .WRITE_POINTER_RESET_N(wrst_n), .WRITE_WORD_IN(wd),
        .READ_SIDE_CLOCK(rclk), .READ_ENABLE_N(ren_n), .READ_POINTER_RESET_N(rrst_n),
        .READ_READY(rrdy), .READ_VALID(rv), .READ_WORD_OUT(rd), .READ_WORD_OE(oe));
    dclf_consumer i_dclf_consumer (.rclk(rclk), .run(run), .prst(prst), .valid(rv),
        .word(rd), .enable_n(ren_n), .ready(rrdy), .ptr_reset_n(rrst_n), .count(cnt));
    ////////////////////
    function automatic logic [7:0] pat(int i);
        return i[7:0] ^ i[12:5];
    endfunction
    task automatic check(logic [7:0] got, logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t word %h exp %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        if (err_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // reset cycle has enable low too, and must win
    task automatic write_line(int n);
        int i;
        int t;
        bit g;
        bit last;
        i = 0;
        t = 0;
        last = 0;
        @(posedge clk);
        wrst_n <= 0;
        we_n <= 0;
        while (i < n) begin
            @(posedge clk);
            g = (t % 97) == 50;
            t++;
            wrst_n <= 1;
            wd <= last ? pat(i - 1) : 8'ha5;
            we_n <= g;
            last = !g;
            if (!g) i++;
        end
        @(posedge clk);
        wd <= pat(i - 1);
        we_n <= 1;
        @(posedge clk);
    endtask
    // first four places were overwritten after the wrap
    task automatic read_check(int n);
        int k;
        int l;
        @(posedge rclk);
        prst <= 1;
        @(posedge rclk);
        prst <= 0;
        run <= 1;
        k = 0;
        while (int'(cnt) < n && k < 60000) begin
            @(posedge rclk);
            k++;
        end
        if (k >= 60000) begin
            err_count++;
            $display("[ERR] %0t read side timed out", $time);
        end
        run <= 0;
        for (k = 0; k < n; k++) begin
            l = k % DCLF_DEPTH;
            check(i_dclf_consumer.seen[k], pat(l < 4 ? l + DCLF_DEPTH : l));
        end
    endtask
    ////////////////////
    initial begin
        rst = 1;
        we_n = 1;
        wrst_n = 1;
        wd = 8'h00;
        run = 0;
        prst = 0;
        err_count = 0;
        check_count = 0;
        repeat (6) @(posedge rclk);
        @(posedge clk);
        rst <= 0;
        repeat (10) @(posedge rclk);
        write_line(DCLF_DEPTH + 4);
        read_check(DCLF_DEPTH + 4);
        report_and_stop;
    end
    initial begin
        #1500000;
        err_count++;
        report_and_stop;
    end
endmodule
`default_nettype wire
